// file: adc_input_mux_gain_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module adc_input_mux_gain_control_tb_top;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [15:0] rdata, adc_result, got;
  logic [2:0] pos_chan, neg_chan;
  logic remote_sense, test_volt3, conv_start, conv_busy, st;
  logic [7:0] gain_value;
  int mismatches = 0;
  int num_checks = 0;
  // Core clock at 100 MHz.
  always #5 core_clk = ~core_clk;
  afe_ctrl #(.CONV_CYCLES(20)) dut (.core_clk, .nrst, .addr, .wdata,
    .wr_stb, .rd_stb, .rdata, .adc_result, .pos_chan, .neg_chan,
    .remote_sense, .test_volt3, .gain_value, .conv_start, .conv_busy);
  afe_adc_model adc (.core_clk, .nrst, .conv_start, .pos_chan, .neg_chan,
    .gain_value, .adc_result);
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value at %0t: %h vs %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge core_clk);
    wr_stb <= 1'b0;
    #1;
  endtask
  // The start pulse is seen in the strobe cycle, data in the next only.
  task automatic rd(input logic [3:0] a);
    @(posedge core_clk);
    addr <= a;
    rd_stb <= 1'b1;
    #1 st = conv_start;
    @(posedge core_clk);
    rd_stb <= 1'b0;
    #1 got = rdata;
  endtask
  // Junk in the low nibble must never move the gain.
  task automatic t_gain();
    for (int f = 0; f < 8; f++) begin
      wr(4'h1, {1'b0, f[2:0], 4'hf});
      chk(gain_value, 16'h1 << f);
    end
  endtask
  task automatic t_mux();
    wr(4'h0, 8'h0f);
    rd(4'h5);
    chk({st, 1'b0, pos_chan, 1'b0, neg_chan}, 16'h0155);
    rd(4'h0);
    wr(4'h0, 8'h80);
    rd(4'h5);
    chk({pos_chan, 1'b0, neg_chan}, 16'h0050);
    wr(4'h0, 8'h40);
    rd(4'h2);
    rd(4'h6);
    chk({pos_chan, 1'b0, neg_chan}, 16'h0056);
    wr(4'h0, 8'hc0);
    rd(4'h1);
    chk({pos_chan, 1'b0, neg_chan}, 16'h0056);
    rd(4'h9);
    chk(st, 1'b0);
    chk(got, 16'h0000);
  endtask
  task automatic t_sense();
    logic [7:0] c [4] = '{8'h20, 8'ha0, 8'h30, 8'h10};
    logic [15:0] e [4] = '{16'h0051, 16'h0051, 16'h0051, 16'h0041};
    for (int i = 0; i < 4; i++) begin
      wr(4'h0, c[i]);
      chk({remote_sense, test_volt3}, c[i][5:4]);
      rd(4'(i + 1));
      chk({pos_chan, 1'b0, neg_chan}, e[i]);
    end
  endtask
  // The second read comes mid-conversion; only its channel may be kept.
  task automatic t_conv();
    wr(4'h0, 8'h00);
    rd(4'h3);
    chk(conv_busy, 1'b1);
    repeat (8) @(posedge core_clk);
    rd(4'h4);
    repeat (16) @(posedge core_clk);
    #1 chk(conv_busy, 1'b1);
    repeat (10) @(posedge core_clk);
    rd(4'h4);
    chk(got, 16'h4480);
  endtask
  // Software sets control code zero, a gain of two and input three when it is done.
  task automatic t_defaults();
    wr(4'h0, 8'h00);
    wr(4'h1, 8'h10);
    rd(4'h3);
    chk({gain_value, 1'b0, pos_chan, 1'b0, neg_chan}, 16'h0233);
  endtask
  task automatic stop_test();
    if (mismatches == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // The whole run needs just over a microsecond; this cuts a hang short.
  initial begin
    #50000;
    mismatches++;
    stop_test();
  end
  initial begin
    repeat (10) @(posedge core_clk);
    nrst <= 1'b1;
    #1 chk(gain_value, 16'h0001);
    t_gain();
    t_mux();
    t_sense();
    t_conv();
    t_defaults();
    stop_test();
  end
endmodule
`default_nettype wire

// file: afe_adc_model.sv
`timescale 1ns/1ps
`default_nettype none
module afe_adc_model #(
  parameter int SETTLE = 12
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic conv_start,
  input wire logic [2:0] pos_chan,
  input wire logic [2:0] neg_chan,
  input wire logic [7:0] gain_value,
  output logic [15:0] adc_result
);
  logic [7:0] cnt_q;
  logic take_q;
  logic [15:0] val_q;
  // Channels land a cycle after the start, so the sample is taken then.
  // A new start drops the running conversion and restarts settling.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      take_q <= 1'b0;
      cnt_q <= 8'h00;
      val_q <= 16'h0000;
    end else begin
      take_q <= conv_start;
      if (take_q) begin
        cnt_q <= 8'h00;
        val_q <= {1'b0, pos_chan, 1'b0, neg_chan, gain_value};
      end else if (cnt_q != 8'(SETTLE)) begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end
  // The word keeps moving until settled, so an early capture is wrong.
  assign adc_result = (cnt_q == 8'(SETTLE)) ? val_q : {cnt_q, ~cnt_q};
endmodule
`default_nettype wire

// file: afe_ctrl.sv
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module afe_ctrl #(
  parameter int CONV_CYCLES = afe_pkg::CONV_CYCLES
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [15:0] rdata,
  input wire logic [15:0] adc_result,
  output logic [2:0] pos_chan,
  output logic [2:0] neg_chan,
  output logic remote_sense,
  output logic test_volt3,
  output logic [7:0] gain_value,
  output logic conv_start,
  output logic conv_busy
);
  // Register state, conversion timer and internal strobes.
  logic [3:0] mux_ctrl_q;
  logic [2:0] gain_q;
  logic [2:0] pos_q;
  logic [2:0] neg_q;
  logic [15:0] result_q;
  logic [15:0] rdata_q;
  logic [15:0] adc_s1_q;
  logic [15:0] adc_s2_q;
  logic [15:0] cnt_q;
  logic chan_rd;
  logic pos_set;
  logic neg_set;
  afe_pkg::afe_state_t state_q;
  logic [15:0] run_len_q;

  // Decode positive set mode from a control code.
  function automatic logic pos_sets(input logic [3:0] c);
    // Remote sense owns the positive side, so it never steps.
    pos_sets = (c[1] == 1'b0) && (c[2] == 1'b0);
  endfunction

  // Decode negative set mode from a control code.
  function automatic logic neg_sets(input logic [3:0] c);
    if (c[0]) begin
      neg_sets = 1'b0;
    end else begin
      neg_sets = (c[3] == 1'b0);
    end
  endfunction

  // A read of a multiplexer channel address starts a conversion.
  assign chan_rd = rd_stb && (addr <= afe_pkg::CHAN_LAST);
  assign pos_set = pos_sets(mux_ctrl_q);
  assign neg_set = neg_sets(mux_ctrl_q);

  // Control register keeps bits seven to four and persists until rewritten.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mux_ctrl_q <= afe_pkg::MUX_CTRL_RESET;
    end else if (wr_stb && addr == afe_pkg::MUX_CTRL_OFF) begin
      mux_ctrl_q <= wdata[afe_pkg::FIELD_LSB +: 4];
    end
  end

  // Gain field lands immediately so the switches follow the write.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      gain_q <= afe_pkg::GAIN_RESET;
    end else if (wr_stb && addr == afe_pkg::GAIN_SEL_OFF) begin
      gain_q <= wdata[afe_pkg::GAIN_LSB +: 3];
    end
  end

  // Set-mode multiplexers latch the read channel; hold mode keeps it.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pos_q <= afe_pkg::CHAN_RESET;
      neg_q <= afe_pkg::CHAN_RESET;
    end else if (chan_rd) begin
      if (pos_set) begin
        pos_q <= addr[2:0];
      end
      if (neg_set) begin
        neg_q <= addr[2:0];
      end
    end
  end

  // The converter word comes from the analog side through two flops.
  // Only the second stage is read, and only at the end of the count, when
  // the word has long settled, so no bit can be caught mid-change.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      adc_s1_q <= 16'h0000;
      adc_s2_q <= 16'h0000;
    end else begin
      adc_s1_q <= adc_result;
      adc_s2_q <= adc_s1_q;
    end
  end

  // Conversion timer; a fresh channel read restarts it from zero.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= afe_pkg::AFE_IDLE;
      cnt_q <= 16'h0000;
    end else if (chan_rd) begin
      state_q <= afe_pkg::AFE_CONV;
      cnt_q <= 16'h0000;
    end else begin
      case (state_q)
        afe_pkg::AFE_IDLE: begin
          cnt_q <= 16'h0000;
        end
        afe_pkg::AFE_CONV: begin
          if (cnt_q == 16'(CONV_CYCLES - 1)) begin
            state_q <= afe_pkg::AFE_IDLE;
          end else begin
            cnt_q <= cnt_q + 16'h0001;
          end
        end
        default: begin
          state_q <= afe_pkg::AFE_IDLE;
        end
      endcase
    end
  end

  // An abandoned conversion never updates the held result.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      result_q <= 16'h0000;
    end else if (state_q == afe_pkg::AFE_CONV && !chan_rd &&
                 cnt_q == 16'(CONV_CYCLES - 1)) begin
      result_q <= adc_s2_q;
    end
  end

  // Read data: last completed result on channel reads, zero elsewhere.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= 16'h0000;
    end else if (chan_rd) begin
      rdata_q <= result_q;
    end else begin
      rdata_q <= 16'h0000;
    end
  end

  // Outputs come straight from the registers, start pulse excepted.
  assign rdata = rdata_q;
  assign pos_chan = pos_q;
  assign neg_chan = neg_q;
  assign remote_sense = mux_ctrl_q[1];
  assign test_volt3 = mux_ctrl_q[0];
  assign gain_value = 8'h01 << gain_q;
  assign conv_start = chan_rd;
  assign conv_busy = (state_q == afe_pkg::AFE_CONV);

  // Cycles since the last channel read, held once the conversion ends; used by the timing checks.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      run_len_q <= 16'h0000;
    end else if (chan_rd) begin
      run_len_q <= 16'h0001;
    end else if (conv_busy) begin
      run_len_q <= run_len_q + 16'h0001;
    end
  end

  // Bus events that the checks below are built from.
  sequence s_chan_read;
    rd_stb && addr <= afe_pkg::CHAN_LAST;
  endsequence

  sequence s_bad_read;
    rd_stb && addr > afe_pkg::CHAN_LAST;
  endsequence

  sequence s_gain_write;
    wr_stb && addr == afe_pkg::GAIN_SEL_OFF;
  endsequence

  sequence s_mux_write;
    wr_stb && addr == afe_pkg::MUX_CTRL_OFF;
  endsequence

  // Last counted cycle of a conversion with no new read arriving.
  sequence s_conv_last;
    conv_busy && !rd_stb && run_len_q == 16'(CONV_CYCLES);
  endsequence

  // The switches follow a gain write in the very next cycle.
  a_gain_write_apply: assert property (@(posedge core_clk)
    disable iff (!nrst) s_gain_write |=>
    gain_value == (8'h01 << $past(wdata[6:4])))
    else $error("Gain did not follow the write.");

  // Nothing but a gain write may move the switches.
  a_gain_persist: assert property (@(posedge core_clk)
    disable iff (!nrst) !(wr_stb && addr == afe_pkg::GAIN_SEL_OFF) |=>
    $stable(gain_value))
    else $error("Gain moved without a gain write.");

  // Only the top four data bits reach the control register.
  a_mux_ctrl_field: assert property (@(posedge core_clk)
    disable iff (!nrst) s_mux_write |=>
    mux_ctrl_q == $past(wdata[7:4]))
    else $error("Control field not taken from high bits.");

  // The mode stays in place until software rewrites it.
  a_mux_persist: assert property (@(posedge core_clk)
    disable iff (!nrst) !(wr_stb && addr == afe_pkg::MUX_CTRL_OFF) |=>
    $stable(mux_ctrl_q))
    else $error("Control mode moved without a write.");

  // Remote sense and test voltage follow their data bits.
  a_sense_decode: assert property (@(posedge core_clk)
    disable iff (!nrst) s_mux_write |=>
    remote_sense == $past(wdata[5]) && test_volt3 == $past(wdata[4]))
    else $error("Sense bits not decoded from the code.");

  // A channel read starts the timer from zero.
  a_read_starts_conv: assert property (@(posedge core_clk)
    disable iff (!nrst) s_chan_read |=> conv_busy && cnt_q == 16'h0000)
    else $error("Channel read did not start a conversion.");

  // A read during a conversion starts the count over.
  a_restart_conv: assert property (@(posedge core_clk)
    disable iff (!nrst) s_chan_read and conv_busy |=> cnt_q == 16'h0000)
    else $error("Conversion was not restarted.");

  // An abandoned conversion leaves the held result alone.
  a_abandon_keep: assert property (@(posedge core_clk)
    disable iff (!nrst) s_chan_read and conv_busy |=> $stable(result_q))
    else $error("Abandoned conversion changed the result.");

  // A conversion never runs longer than its count.
  a_conv_length: assert property (@(posedge core_clk)
    disable iff (!nrst) conv_busy |-> run_len_q <= 16'(CONV_CYCLES))
    else $error("Conversion ran past its count.");

  // At the end of the count the settled word is kept and the timer stops.
  a_conv_capture: assert property (@(posedge core_clk)
    disable iff (!nrst) s_conv_last |=>
    !conv_busy && result_q == $past(adc_s2_q))
    else $error("Finished conversion was not captured.");

  // A conversion is still running eight cycles after its read.
  a_conv_ends: assert property (@(posedge core_clk)
    disable iff (!nrst) s_chan_read ##1 (!rd_stb)[*8] |-> conv_busy)
    else $error("Conversion ended too early.");

  // A positive mux in set mode steps to the read channel.
  a_pos_set_step: assert property (@(posedge core_clk)
    disable iff (!nrst) s_chan_read and pos_set |=>
    pos_chan == $past(addr[2:0]))
    else $error("Positive mux did not step.");

  // A negative mux in set mode steps to the read channel.
  a_neg_set_step: assert property (@(posedge core_clk)
    disable iff (!nrst) s_chan_read and neg_set |=>
    neg_chan == $past(addr[2:0]))
    else $error("Negative mux did not step.");

  // A held positive mux ignores the read address.
  a_pos_hold_keep: assert property (@(posedge core_clk)
    disable iff (!nrst) s_chan_read and !pos_set |=> $stable(pos_chan))
    else $error("Positive mux moved while held.");

  // A held negative mux ignores the read address.
  a_neg_hold_keep: assert property (@(posedge core_clk)
    disable iff (!nrst) s_chan_read and !neg_set |=> $stable(neg_chan))
    else $error("Negative mux moved while held.");

  // In differential mode both muxes step together on a read.
  a_diff_both_step: assert property (@(posedge core_clk)
    disable iff (!nrst)
    s_chan_read and mux_ctrl_q == afe_pkg::MUX_CTRL_RESET |=>
    pos_chan == $past(addr[2:0]) && neg_chan == $past(addr[2:0]))
    else $error("Muxes did not step together.");

  // Remote sense owns the positive side, so it must not step.
  a_remote_pos_hold: assert property (@(posedge core_clk)
    disable iff (!nrst) s_chan_read and remote_sense |=> $stable(pos_chan))
    else $error("Positive mux moved under remote sense.");

  // Test voltage three owns the negative side, so it must not step.
  a_tv3_neg_hold: assert property (@(posedge core_clk)
    disable iff (!nrst) s_chan_read and test_volt3 |=> $stable(neg_chan))
    else $error("Negative mux moved under test voltage.");

  // A channel read hands back the last completed result.
  a_read_returns: assert property (@(posedge core_clk)
    disable iff (!nrst) s_chan_read |=> rdata == $past(result_q))
    else $error("Read did not return the held result.");

  // Read data stand only in the cycle after a read strobe and are zero otherwise.
  a_rdata_idle: assert property (@(posedge core_clk)
    disable iff (!nrst) !rd_stb |=> rdata == 16'h0000)
    else $error("Read data shown without a read.");

  // Reads outside the channel range start nothing and return zero.
  a_bad_read_quiet: assert property (@(posedge core_clk)
    disable iff (!nrst) s_bad_read |->
    !conv_start ##1 (rdata == 16'h0000))
    else $error("Out of range read was not refused.");
endmodule
`default_nettype wire

// file: afe_pkg.sv
// Summary of operation
// - Code x x 1 0 gives remote sense; D7 0 sets, 1 holds negative; 11 test.
// - Gain field bits six to four selects gain two to the field, 1..128.
// - Low four bits of a gain write are ignored.
// - New gain applies at once on the write, no conversion needed.
// - Host writes control and gain, then a channel read starts conversion.
// - A new channel read abandons and restarts a running conversion.
// - In set mode a channel read steps both muxes and starts a conversion.
// - Mux control persists until rewritten; reads alone start conversions.
// - Control field is bits seven to four; bits three to zero ignored.
// - Codes decode to set/hold per mux and test voltage three selection.
// - Low read address bits pick the same input on both multiplexers in set mode.
package afe_pkg;
  localparam logic [3:0] MUX_CTRL_OFF = 4'h0;
  localparam logic [3:0] GAIN_SEL_OFF = 4'h1;
  localparam logic [3:0] CHAN_LAST = 4'h7;
  localparam int FIELD_LSB = 4;
  localparam int GAIN_LSB = 4;
  localparam int CONV_TIME_NS = 13200;
  localparam int CLK_PERIOD_NS = 10;
  localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) /
    CLK_PERIOD_NS;
  localparam logic [3:0] MUX_CTRL_RESET = 4'h0;
  localparam logic [2:0] GAIN_RESET = 3'h0;
  localparam logic [2:0] CHAN_RESET = 3'h0;
  typedef enum logic [0:0] {
    AFE_IDLE = 1'b0,
    AFE_CONV = 1'b1
  } afe_state_t;
endpackage
